// >>> core/ipct_pkg.sv
// Purpose: Shared constants, mode tables and tick conversion for the PIO cycle ends
// Assumes: one clock clk_sys at 10 MHz; both ends on that clock
// Notes:   mode index 0..6 selects a column of every table
// Functional notes
// - Host keeps strobe-to-strobe cycle above mode minimum
// - Host holds strobe active; 8-bit registers longer
// - Host keeps strobes inactive for recovery minimum
// - Cycle is active plus inactive; any lengthening legal
// - Card releases data bus after read strobe ends
// - Host samples ready one set-up after strobe
// - Ready low at sample: host waits for ready
// - Card never holds ready low beyond 1250 ns
// - Modes 5 and 6: no waits, ready ignored
// - Card drives 16-bit indication in modes 0-2
// - Host ignores 16-bit indication in modes 3+
// - Selects and address decode register, held around strobe
// - Data path is 16 bits or low byte
// - Card keeps ready high when no wait needed; this card drops ready on every read in modes 0-4
// - Ready low before sample inserts wait until high
// - Read data valid no later than ready reassertion
// - Stretched read: host captures data at ready
package ipct_pkg;
    localparam int CLK_NS = 100;
    localparam int MODES  = 7;
    localparam int WORD_W = 16;
    localparam int REG_W  = 4;
    localparam int CNT_W  = 8;
    typedef int ipct_tab_t [MODES];
    // Per-mode minimums and maximums in ns
    localparam ipct_tab_t T0_NS  = '{600, 383, 240, 180, 120, 100, 80};
    localparam ipct_tab_t T1_NS  = '{70, 50, 30, 30, 25, 15, 10};
    localparam ipct_tab_t T2_NS  = '{165, 125, 100, 80, 70, 65, 55};
    localparam ipct_tab_t T2B_NS = '{290, 290, 290, 80, 70, 65, 55};
    localparam ipct_tab_t T2I_NS = '{283, 673, 85, 70, 25, 25, 20};
    localparam ipct_tab_t T9_NS  = '{20, 15, 10, 10, 10, 10, 10};
    localparam ipct_tab_t T6Z_NS = '{30, 30, 30, 30, 30, 20, 20};
    localparam int TA_NS  = 35;
    localparam int TB_NS  = 1250;
    localparam int T7_NS  = 40;
    // Mode thresholds and register ids
    localparam logic [2:0] MODE_NO_WAIT = 3'h5;
    localparam logic [2:0] MODE_NO_CS16 = 3'h3;
    localparam logic [REG_W-1:0] REG_DATA = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    // Least read strobe cycles without ready: card needs request plus answer
    localparam logic [CNT_W-1:0] RD_TURN_CYC = 8'h03;

    // Least time to whole cycles, rounded up, at least one
    function automatic logic [CNT_W-1:0] cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) c = 1;
        return c[CNT_W-1:0];
    endfunction : cyc_up

    // Longest time to whole cycles, rounded down, at least one
    function automatic logic [CNT_W-1:0] cyc_dn(input int ns);
        int c;
        c = ns / CLK_NS;
        if (c < 1) c = 1;
        return c[CNT_W-1:0];
    endfunction : cyc_dn

    localparam logic [CNT_W-1:0] TA_CYC = cyc_up(TA_NS);
    localparam logic [CNT_W-1:0] TB_CYC = cyc_dn(TB_NS);
endpackage : ipct_pkg

// >>> core/ipct_if.sv
// Purpose: Parallel task-file bus between host end and card end
// Assumes: both ends clocked by clk_sys
// Notes:   undriven data lanes read as all ones, as with pull-ups
interface ipct_if;
    import ipct_pkg::*;
    logic                read_strobe_n;
    logic                write_strobe_n;
    logic                card_select_low_n;
    logic                card_select_high_n;
    logic [2:0]          register_address;
    logic [WORD_W-1:0]   h_dout;
    logic [1:0]          h_oe;
    logic [WORD_W-1:0]   d_dout;
    logic [1:0]          d_oe;
    logic                iordy;
    logic                iocs16_n;
    logic [WORD_W-1:0]   host_data_bus;

    // Wire level per byte lane from the enables
    assign host_data_bus[7:0]  = h_oe[0] ? h_dout[7:0]  : d_oe[0] ? d_dout[7:0]  : 8'hFF;
    assign host_data_bus[15:8] = h_oe[1] ? h_dout[15:8] : d_oe[1] ? d_dout[15:8] : 8'hFF;

    modport host (output read_strobe_n, write_strobe_n, card_select_low_n, card_select_high_n,
                  register_address, h_dout, h_oe, input host_data_bus, iordy, iocs16_n);
    modport device (input read_strobe_n, write_strobe_n, card_select_low_n, card_select_high_n,
                    register_address, host_data_bus, output d_dout, d_oe, iordy, iocs16_n);
endinterface : ipct_if

// >>> core/ipct_device.sv
// Purpose: Card end of the PIO cycle: decode, ready stretch, data drive, write buffer
// Assumes: host keeps its timing; user answers read requests
// Notes:   writes land in a DEPTH-entry buffer; a full buffer stretches the cycle in modes 0-4 and drops the word in modes 5-6
module ipct_device #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // Bus
    ipct_if.device                           bus,
    // Configuration
    input  wire logic [2:0]                  mode,
    input  wire logic                        wide_en,
    // Write stream out
    output logic                             wr_valid,
    input  wire logic                        wr_ready,
    output logic [ipct_pkg::REG_W-1:0]       wr_reg,
    output logic [ipct_pkg::WORD_W-1:0]      wr_data,
    // Read request and answer
    output logic                             rd_req,
    output logic [ipct_pkg::REG_W-1:0]       rd_reg,
    input  wire logic                        rd_valid,
    input  wire logic [ipct_pkg::WORD_W-1:0] rd_data,
    // Error pulse
    output logic                             overrun
);
    import ipct_pkg::*;
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int EW = REG_W + WORD_W;
    typedef enum {D_IDLE, D_RD_WAIT, D_WR_WAIT, D_HOLD} ipct_dst_t;

    ipct_dst_t            st_reg, st_next;
    logic                 iordy_reg, iordy_next;
    logic [WORD_W-1:0]    dq_reg, dq_next;
    logic [1:0]           oe_reg, oe_next;
    logic                 cs16_n_reg;
    logic                 req_reg, req_next;
    logic [REG_W-1:0]     rreg_reg;
    logic                 ovr_reg, ovr_next;
    logic [CNT_W-1:0]     wcnt_reg, wcnt_next;
    logic [EW-1:0]        mem [DEPTH];
    logic [PW-1:0]        wp_reg, rp_reg, rp_next;
    logic [PW:0]          cnt_reg, cnt_next, left;
    logic                 push;
    logic                 pop;
    logic                 hv_reg;
    logic [EW-1:0]        head_reg, head_next;

    // Register decode from both selects and address
    wire                  sel      = !bus.card_select_low_n || !bus.card_select_high_n;
    wire [REG_W-1:0]      reg_id   = {bus.card_select_low_n, bus.register_address};
    wire                  rd_act   = sel && !bus.read_strobe_n;
    wire                  wr_act   = sel && !bus.write_strobe_n;
    wire                  wide_cyc = wide_en && (reg_id == REG_DATA);
    wire [1:0]            lanes    = wide_cyc ? 2'h3 : 2'h1;
    wire [WORD_W-1:0]     wr_word  = wide_cyc ? bus.host_data_bus : {8'h00, bus.host_data_bus[7:0]};
    wire [WORD_W-1:0]     rd_word  = wide_cyc ? rd_data : {8'h00, rd_data[7:0]};
    wire                  can_wait = mode < MODE_NO_WAIT;
    wire                  tmo      = wcnt_reg >= TB_CYC - CNT_ONE;
    wire                  full     = cnt_reg == (PW + 1)'(DEPTH);
    wire                  answer   = req_reg && rd_valid;

    // Cycle sequencing and ready stretch
    always_comb begin
        st_next    = st_reg;
        iordy_next = 1'b1;
        dq_next    = dq_reg;
        oe_next    = oe_reg;
        req_next   = req_reg;
        ovr_next   = 1'b0;
        wcnt_next  = 8'h00;
        push       = 1'b0;
        case (st_reg)
            D_IDLE: begin
                if (rd_act) begin
                    req_next   = 1'b1;
                    iordy_next = !can_wait;
                    st_next    = D_RD_WAIT;
                end else if (wr_act) begin
                    if (!full) begin
                        push    = 1'b1;
                        st_next = D_HOLD;
                    end else if (can_wait) begin
                        iordy_next = 1'b0;
                        st_next    = D_WR_WAIT;
                    end else begin
                        ovr_next = 1'b1;
                        st_next  = D_HOLD;
                    end
                end
            end
            D_RD_WAIT: begin
                wcnt_next = wcnt_reg + CNT_ONE;
                if (!rd_act) begin
                    req_next = 1'b0;
                    ovr_next = 1'b1;
                    st_next  = D_IDLE;
                end else if (answer || (can_wait && tmo)) begin
                    dq_next  = rd_word;
                    oe_next  = lanes;
                    req_next = 1'b0;
                    ovr_next = !answer;
                    st_next  = D_HOLD;
                end else begin
                    iordy_next = !can_wait;
                end
            end
            D_WR_WAIT: begin
                wcnt_next = wcnt_reg + CNT_ONE;
                if (!wr_act) begin
                    ovr_next = 1'b1;
                    st_next  = D_IDLE;
                end else if (!full) begin
                    push    = 1'b1;
                    st_next = D_HOLD;
                end else if (tmo) begin
                    ovr_next = 1'b1;
                    st_next  = D_HOLD;
                end else begin
                    iordy_next = 1'b0;
                end
            end
            D_HOLD: begin
                if (!rd_act && !wr_act) begin
                    oe_next = 2'h0;
                    st_next = D_IDLE;
                end
            end
            default: st_next = D_IDLE;
        endcase
    end

    // Buffer bookkeeping; head word is registered so outputs come from flops
    assign pop       = hv_reg && wr_ready;
    assign rp_next   = pop ? rp_reg + 1'b1 : rp_reg;
    assign cnt_next  = cnt_reg + (PW + 1)'(push) - (PW + 1)'(pop);
    assign left      = cnt_reg - (PW + 1)'(pop);
    assign head_next = (left == '0) ? {reg_id, wr_word} : mem[rp_next];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg    <= D_IDLE;
            iordy_reg <= 1'b1;
            dq_reg    <= 16'h0000;
            oe_reg    <= 2'h0;
            req_reg   <= 1'b0;
            ovr_reg   <= 1'b0;
            wcnt_reg  <= 8'h00;
        end else begin
            st_reg    <= st_next;
            iordy_reg <= iordy_next;
            dq_reg    <= dq_next;
            oe_reg    <= oe_next;
            req_reg   <= req_next;
            ovr_reg   <= ovr_next;
            wcnt_reg  <= wcnt_next;
        end
    end

    // Indication and register id for the read side
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs16_n_reg <= 1'b1;
            rreg_reg   <= 4'h0;
        end else begin
            cs16_n_reg <= !(sel && wide_cyc && mode < MODE_NO_CS16);
            rreg_reg   <= reg_id;
        end
    end

    // Buffer storage; pointers wrap by index
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wp_reg   <= '0;
            rp_reg   <= '0;
            cnt_reg  <= '0;
            hv_reg   <= 1'b0;
            head_reg <= '0;
            for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
        end else begin
            if (push) begin
                mem[wp_reg] <= {reg_id, wr_word};
                wp_reg      <= (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
            end
            rp_reg   <= (pop && rp_reg == PW'(DEPTH - 1)) ? '0 : rp_next;
            cnt_reg  <= cnt_next;
            hv_reg   <= cnt_next != '0;
            head_reg <= head_next;
        end
    end

    assign bus.iordy    = iordy_reg;
    assign bus.d_dout   = dq_reg;
    assign bus.d_oe     = oe_reg;
    assign bus.iocs16_n = cs16_n_reg;
    assign wr_valid     = hv_reg;
    assign wr_reg       = head_reg[EW-1:WORD_W];
    assign wr_data      = head_reg[WORD_W-1:0];
    assign rd_req       = req_reg;
    assign rd_reg       = rreg_reg;
    assign overrun      = ovr_reg;
endmodule : ipct_device

// >>> core/ipct_host.sv
// Purpose: Host end of the PIO cycle: setup, strobe, ready sampling, recovery
// Assumes: mode stable while a command is accepted
// Notes:   counts are reloaded from the tables at each accepted command
module ipct_host (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // Bus
    ipct_if.host                             bus,
    // Configuration
    input  wire logic [2:0]                  mode,
    // Command
    input  wire logic                        cmd_valid,
    output logic                             cmd_ready,
    input  wire logic                        cmd_write,
    input  wire logic [ipct_pkg::REG_W-1:0]  cmd_reg,
    input  wire logic                        cmd_wide,
    input  wire logic [ipct_pkg::WORD_W-1:0] cmd_wdata,
    // Response
    output logic                             rsp_valid,
    output logic [ipct_pkg::WORD_W-1:0]      rsp_data,
    output logic                             rsp_wide,
    output logic                             rsp_stretched
);
    import ipct_pkg::*;
    typedef enum {H_IDLE, H_SETUP, H_ACTIVE, H_RECOVER} ipct_hst_t;

    ipct_hst_t            st_reg;
    logic [CNT_W-1:0]     cnt_reg;
    logic [CNT_W-1:0]     cyc_reg;
    logic [CNT_W-1:0]     set_cyc_reg, act_cyc_reg, rec_cyc_reg, tot_cyc_reg, hold_cyc_reg;
    logic                 wait_reg;
    logic                 cs16_ok_reg;
    logic                 wr_reg;
    logic                 wide_reg;
    logic                 rd_n_reg, wr_n_reg, csl_n_reg, csh_n_reg;
    logic [2:0]           addr_reg;
    logic [WORD_W-1:0]    dout_reg;
    logic [1:0]           oe_reg;
    logic                 rdy_reg;
    logic                 rv_reg;
    logic [WORD_W-1:0]    rd_reg;
    logic                 rw_reg;
    logic                 str_reg;
    logic                 cs16_seen_reg;

    // Counts for the mode at hand, rounded up
    wire [2:0]            m        = (mode < 3'(MODES)) ? mode : 3'h0;
    wire                  reg8     = !(cmd_wide && cmd_reg == REG_DATA);
    wire [CNT_W-1:0]      set_cyc  = cyc_up(T1_NS[m]);
    wire [CNT_W-1:0]      act_min  = cyc_up(reg8 ? T2B_NS[m] : T2_NS[m]);
    // No ready in the fast modes, so a read strobe is lengthened to outlast the
    // card's answer; the card's user must then answer in the cycle it is asked
    wire [CNT_W-1:0]      act_cyc  = (!cmd_write && m >= MODE_NO_WAIT && act_min < RD_TURN_CYC) ?
                                     RD_TURN_CYC : act_min;
    wire [CNT_W-1:0]      rec_cyc  = cyc_up(T2I_NS[m]);
    wire [CNT_W-1:0]      tot_cyc  = cyc_up(T0_NS[m]);
    wire [CNT_W-1:0]      hold_cyc = cyc_up(T9_NS[m]);
    wire                  take     = rdy_reg && cmd_valid;

    // Strobe phase decisions
    wire                  set_done = cnt_reg + CNT_ONE >= set_cyc_reg;
    wire                  sampled  = cnt_reg >= TA_CYC;
    wire                  ready_in = !wait_reg || (sampled && bus.iordy);
    wire                  act_done = (cnt_reg + CNT_ONE >= act_cyc_reg) && ready_in;
    wire                  stall    = wait_reg && sampled && !bus.iordy;
    wire [CNT_W-1:0]      rec_need = (rec_cyc_reg > hold_cyc_reg) ? rec_cyc_reg : hold_cyc_reg;
    wire                  rec_done = (cnt_reg + CNT_ONE >= rec_need) &&
                                     (cyc_reg + CNT_ONE >= tot_cyc_reg);
    wire [CNT_W-1:0]      cnt_inc  = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + CNT_ONE;
    wire [CNT_W-1:0]      cyc_inc  = (cyc_reg == CNT_MAX) ? cyc_reg : cyc_reg + CNT_ONE;
    wire [1:0]            lanes    = cmd_wide ? 2'h3 : 2'h1;
    wire                  cs16_now = cs16_ok_reg && !bus.iocs16_n;

    // Phase sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg  <= H_IDLE;
            cnt_reg <= 8'h00;
            cyc_reg <= 8'h00;
        end else begin
            case (st_reg)
                H_IDLE: begin
                    cnt_reg <= 8'h00;
                    if (take) st_reg <= H_SETUP;
                end
                H_SETUP: begin
                    cnt_reg <= set_done ? 8'h00 : cnt_inc;
                    cyc_reg <= 8'h00;
                    if (set_done) st_reg <= H_ACTIVE;
                end
                H_ACTIVE: begin
                    cnt_reg <= act_done ? 8'h00 : cnt_inc;
                    cyc_reg <= cyc_inc;
                    if (act_done) st_reg <= H_RECOVER;
                end
                H_RECOVER: begin
                    cnt_reg <= cnt_inc;
                    cyc_reg <= cyc_inc;
                    if (rec_done) st_reg <= H_IDLE;
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end

    // Per-command counts loaded when the command is taken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            set_cyc_reg  <= CNT_ONE;
            act_cyc_reg  <= CNT_ONE;
            rec_cyc_reg  <= CNT_ONE;
            tot_cyc_reg  <= CNT_ONE;
            hold_cyc_reg <= CNT_ONE;
            wait_reg     <= 1'b0;
            cs16_ok_reg  <= 1'b0;
            wr_reg       <= 1'b0;
            wide_reg     <= 1'b0;
        end else if (take) begin
            set_cyc_reg  <= set_cyc;
            act_cyc_reg  <= act_cyc;
            rec_cyc_reg  <= rec_cyc;
            tot_cyc_reg  <= tot_cyc;
            hold_cyc_reg <= hold_cyc;
            wait_reg     <= m < MODE_NO_WAIT;
            cs16_ok_reg  <= m < MODE_NO_CS16;
            wr_reg       <= cmd_write;
            wide_reg     <= cmd_wide;
        end
    end

    // Pin drive: selects and address held through recovery
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_n_reg  <= 1'b1;
            wr_n_reg  <= 1'b1;
            csl_n_reg <= 1'b1;
            csh_n_reg <= 1'b1;
            addr_reg  <= 3'h0;
            dout_reg  <= 16'h0000;
            oe_reg    <= 2'h0;
        end else begin
            if (take) begin
                csl_n_reg <= cmd_reg[3];
                csh_n_reg <= !cmd_reg[3];
                addr_reg  <= cmd_reg[2:0];
                dout_reg  <= cmd_wide ? cmd_wdata : {8'h00, cmd_wdata[7:0]};
                oe_reg    <= cmd_write ? lanes : 2'h0;
            end else if (st_reg == H_RECOVER && rec_done) begin
                csl_n_reg <= 1'b1;
                csh_n_reg <= 1'b1;
                oe_reg    <= 2'h0;
            end
            rd_n_reg <= !((st_reg == H_SETUP && set_done && !wr_reg) ||
                          (st_reg == H_ACTIVE && !act_done && !wr_reg));
            wr_n_reg <= !((st_reg == H_SETUP && set_done && wr_reg) ||
                          (st_reg == H_ACTIVE && !act_done && wr_reg));
        end
    end

    // Command handshake, read capture and response
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdy_reg       <= 1'b0;
            rv_reg        <= 1'b0;
            rd_reg        <= 16'h0000;
            rw_reg        <= 1'b0;
            str_reg       <= 1'b0;
            cs16_seen_reg <= 1'b0;
        end else begin
            rdy_reg <= (st_reg == H_IDLE && !take) || (st_reg == H_RECOVER && rec_done);
            rv_reg  <= st_reg == H_RECOVER && rec_done;
            if (take) begin
                str_reg       <= 1'b0;
                cs16_seen_reg <= 1'b0;
            end
            if (st_reg == H_ACTIVE) begin
                if (stall) str_reg <= 1'b1;
                if (cs16_now) cs16_seen_reg <= 1'b1;
            end
            if (st_reg == H_ACTIVE && act_done && !wr_reg) begin
                rd_reg <= wide_reg ? bus.host_data_bus : {8'h00, bus.host_data_bus[7:0]};
            end
            if (st_reg == H_RECOVER && rec_done) begin
                rw_reg <= cs16_ok_reg ? (wide_reg && cs16_seen_reg) : wide_reg;
            end
        end
    end

    assign bus.read_strobe_n      = rd_n_reg;
    assign bus.write_strobe_n     = wr_n_reg;
    assign bus.card_select_low_n  = csl_n_reg;
    assign bus.card_select_high_n = csh_n_reg;
    assign bus.register_address   = addr_reg;
    assign bus.h_dout             = dout_reg;
    assign bus.h_oe               = oe_reg;
    assign cmd_ready              = rdy_reg;
    assign rsp_valid              = rv_reg;
    assign rsp_data               = rd_reg;
    assign rsp_wide               = rw_reg;
    assign rsp_stretched          = str_reg;
endmodule : ipct_host

// >>> sim/ipct_bus_properties.sv
// Purpose: Bus checks between host end and card end
// Assumes: one clock clk_sys; rst active high
// Notes:   mode is not on the bus, so only mode-free rules here
module ipct_bus_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Bus
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       card_select_low_n,
    input wire logic       card_select_high_n,
    input wire logic [2:0] register_address,
    input wire logic [1:0] d_oe,
    input wire logic       iordy,
    input wire logic       iocs16_n
);
    // Single domain, so one clocking and one disable for all
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Strobe activity and device selection
    wire act = !read_strobe_n || !write_strobe_n;
    wire sel = !card_select_low_n || !card_select_high_n;
    AST_READY_BOUND: assert property ($fell(iordy) |-> ##[1:12] iordy)
        else $error("ready held low too long");
    AST_RD_RELEASE: assert property ($rose(read_strobe_n) |=> d_oe == 2'h0)
        else $error("card still drives after read");
    AST_RECOVERY: assert property ($fell(act) |=> !act [*2])
        else $error("recovery too short");
    AST_SEL_DURING: assert property (act |-> sel && $stable(register_address))
        else $error("address moved under strobe");
    AST_SEL_HOLD: assert property ($fell(act) |-> sel && $stable(register_address))
        else $error("address not held after strobe");
    AST_DATA_AT_READY: assert property ($rose(iordy) && !read_strobe_n |-> d_oe != 2'h0)
        else $error("ready rose without data");
    AST_READY_IDLE: assert property (!iordy |-> act)
        else $error("ready low outside a cycle");
    AST_CS16_CAUSE: assert property (!iocs16_n |-> $past(!card_select_low_n && register_address == 3'h0))
        else $error("wide flag without data register");
endmodule : ipct_bus_chk

// >>> sim/test_ide_pio_cycle_timing.sv
// Purpose: Directed bench for host and card ends joined by the bus
// Assumes: clk_sys 100 ns; card user side answers reads after rd_delay
// Notes:   full write buffer forces a stretch and a dropped word
module test_ide_pio_cycle_timing;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rst, cmd_valid, cmd_ready, cmd_write, cmd_wide, rsp_valid, rsp_wide;
    logic        rsp_stretched, wide_en, wr_valid, wr_ready, rd_req, rd_valid, overrun;
    logic [2:0]  mode;
    logic [3:0]  cmd_reg, rd_reg, wr_id, wr_last;
    logic [15:0] cmd_wdata, rsp_data, wr_data, rd_data;
    logic [15:0] wq[$];
    int          errors, check_count, rd_delay, wait_cnt, ovr_cnt;
    ipct_if bus ();
    ipct_host u_ipct_host (.clk_sys, .rst, .bus(bus.host), .mode, .cmd_valid, .cmd_ready, .cmd_write,
        .cmd_reg, .cmd_wide, .cmd_wdata, .rsp_valid, .rsp_data, .rsp_wide, .rsp_stretched);
    ipct_device #(.DEPTH(2)) u_ipct_device (.clk_sys, .rst, .bus(bus.device), .mode, .wide_en, .wr_valid,
        .wr_ready, .wr_reg(wr_id), .wr_data, .rd_req, .rd_reg, .rd_valid, .rd_data, .overrun);
    ipct_bus_chk u_chk (.clk_sys, .rst, .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
        .card_select_low_n(bus.card_select_low_n), .card_select_high_n(bus.card_select_high_n),
        .register_address(bus.register_address), .d_oe(bus.d_oe), .iordy(bus.iordy), .iocs16_n(bus.iocs16_n));
    // Clock and hang guard
    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        errors++;
        close_out();
    end
    // Read answer after rd_delay cycles; slow answers force a stretch
    always @(negedge clk_sys) begin
        wait_cnt = rd_req ? wait_cnt + 1 : 0;
        rd_valid = rd_req && wait_cnt > rd_delay;
        rd_data  = {12'hC3A, rd_reg};
    end
    // Words leaving the write buffer, and error pulses
    always @(posedge clk_sys) begin
        if (wr_valid && wr_ready) begin
            wq.push_back(wr_data);
            wr_last = wr_id;
        end
        if (overrun === 1'b1) ovr_cnt++;
    end
    function automatic logic [15:0] pop();
        return wq.size() ? wq.pop_front() : 16'hX;
    endfunction : pop
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // One command, entered at a falling edge, bounded wait for the answer
    task automatic do_cmd(input logic wr, input logic [3:0] rg, input logic wd, input logic [15:0] wdat);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        {cmd_valid, cmd_write, cmd_reg, cmd_wide, cmd_wdata} = {1'b1, wr, rg, wd, wdat};
        @(negedge clk_sys);
        cmd_valid = 0;
        while (rsp_valid !== 1'b1 && n < 80) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 80) errors++;
    endtask : do_cmd
    task automatic close_out();
        if (errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // Every mode: write, wide read, byte read on the other select; slow read in modes 0-4 only
    initial begin
        {rst, cmd_valid, cmd_write, cmd_wide, wide_en, wr_ready} = 6'h23;
        {mode, cmd_reg, cmd_wdata, rd_delay} = '0;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 0;
        for (int m = 0; m < 7; m++) begin
            mode = 3'(m);
            rd_delay = 0;
            do_cmd(1'b1, 4'h0, 1'b1, 16'h5A00 | 16'(m));
            check({15'h0, rsp_stretched}, 16'h0);
            check(pop(), 16'h5A00 | 16'(m));
            do_cmd(1'b1, 4'h9, 1'b0, 16'hA5C0 | 16'(m));
            check(pop(), 16'h00C0 | 16'(m));
            check({12'h0, wr_last}, 16'h0009);
            do_cmd(1'b0, 4'h0, 1'b1, 16'h0);
            check(rsp_data, 16'hC3A0);
            check({15'h0, rsp_wide}, 16'h1);
            do_cmd(1'b0, 4'h9, 1'b0, 16'h0);
            check(rsp_data, 16'h00A9);
            if (m > 4) check({15'h0, rsp_stretched}, 16'h0);
            else begin
                rd_delay = 5;
                do_cmd(1'b0, 4'h0, 1'b1, 16'h0);
                check({15'h0, rsp_stretched}, 16'h1);
                check(rsp_data, 16'hC3A0);
            end
        end
        // Receiver stalls: two words fit, the third stretches and is lost
        mode = 3'h0;
        wr_ready = 0;
        for (int k = 1; k < 4; k++) begin
            do_cmd(1'b1, 4'h0, 1'b1, 16'h1111 * 16'(k));
            check({15'h0, rsp_stretched}, {15'h0, k == 3});
        end
        wr_ready = 1;
        repeat (4) @(negedge clk_sys);
        check(pop(), 16'h1111);
        check(pop(), 16'h2222);
        check(16'(wq.size()), 16'h0);
        check(16'(ovr_cnt), 16'h1);
        close_out();
    end
endmodule : test_ide_pio_cycle_timing
